/* hdl/lagsel_defines.svh */
`ifndef LAGSEL_DEFINES_SVH
`define LAGSEL_DEFINES_SVH
`define LAGSEL_NPORTS 10
`define LAGSEL_NGROUPS 5
`define LAGSEL_GRP_NONE 3'h0
`define LAGSEL_GRP_MAX 3'h5
`define LAGSEL_FIFO_DEPTH 16
`define LAGSEL_OFF_HASH 8'h00
`define LAGSEL_OFF_PGRP 8'h04
`define LAGSEL_OFF_GTYPE 8'h08
`define LAGSEL_OFF_LIMIT 8'h0c
`define LAGSEL_OFF_MIRROR 8'h10
`define LAGSEL_OFF_GSEL 8'h14
`define LAGSEL_OFF_GSTAT 8'h18
`define LAGSEL_OFF_GNAME 8'h1c
`define LAGSEL_HB_SMAC 0
`define LAGSEL_HB_DMAC 1
`define LAGSEL_HB_IP 2
`define LAGSEL_HB_L4 3
`define LAGSEL_HASH_RST 4'hd
`define LAGSEL_LIMIT_RST 4'h8
`define LAGSEL_LIMIT_MAX 4'ha
`define LAGSEL_NAME_BASE 32'h4c414730
`define LAGSEL_MIR_DST_LSB 16
`endif

/* hdl/lagsel_pkg.sv */
`include "lagsel_defines.svh"
package lagsel_pkg;
   typedef struct packed {
      logic [47:0] smac;
      logic [47:0] dmac;
      logic ipv4;
      logic [31:0] sip;
      logic [31:0] dip;
      logic [15:0] sport;
      logic [15:0] dport;
      logic [2:0] grp;
      logic [3:0] port;
   } lagsel_hdr_s;
   typedef struct packed {
      logic [1:0] speed;
      logic fdx;
      logic up;
   } lagsel_link_s;
   typedef struct packed {
      logic lacp;
      logic [1:0] speed;
      logic [9:0] cfg;
      logic [9:0] agg;
   } lagsel_grp_s;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } lagsel_bus_e;
endpackage : lagsel_pkg

/* hdl/lagsel_fifo.sv */
`timescale 1ns/10ps
module lagsel_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
   logic full, empty, push, pop;

   assign empty = (wr_reg == rd_reg);
   assign full = (wr_reg[AW] != rd_reg[AW]) &&
                 (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem_reg[rd_reg[AW-1:0]];
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;

   always_comb begin
      wr_next = wr_reg + (AW+1)'(push);
      rd_next = rd_reg + (AW+1)'(pop);
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data_i;
      end
   end
endmodule : lagsel_fifo

/* hdl/lagsel_hash.sv */
`timescale 1ns/10ps
module lagsel_hash
   import lagsel_pkg::*;
(
   // Header and field enables
   input wire lagsel_hdr_s hdr_i,
   input wire logic [3:0] en_i,
   // Flow code
   output logic [15:0] hash_o
);
   function automatic logic [15:0] fold48(input logic [47:0] v);
      fold48 = v[47:32] ^ v[31:16] ^ v[15:0];
   endfunction : fold48

   logic [15:0] h;
   logic [15:0] dm;
   always_comb begin
      h = 16'h0000;
      dm = fold48(hdr_i.dmac);
      if (en_i[`LAGSEL_HB_SMAC]) begin
         h = h ^ fold48(hdr_i.smac);
      end
      if (en_i[`LAGSEL_HB_DMAC]) begin
         h = h ^ {dm[7:0], dm[15:8]};
      end
      if (en_i[`LAGSEL_HB_IP] && hdr_i.ipv4) begin
         h = h ^ hdr_i.sip[31:16] ^ hdr_i.sip[15:0] ^ hdr_i.dip[31:16]
             ^ hdr_i.dip[15:0];
      end
      if (en_i[`LAGSEL_HB_L4] && hdr_i.ipv4) begin
         h = h ^ hdr_i.sport ^ hdr_i.dport;
      end
      hash_o = h ^ {h[10:0], h[15:11]};
   end
endmodule : lagsel_hash

/* hdl/lagsel_top.sv */
// Overview of operation
// - One flow always leaves on one member
// - Hash MACs, IPv4 addresses, IPv4 L4 ports
// - Source MAC enable, on after reset
// - Destination MAC enable, off after reset
// - IP address enable, on after reset
// - L4 port enable, on after reset
// - Hash enables global, membership per port
// - One group per port, zero means none
// - No port in any group after reset
// - At most ten aggregated ports, ten per group
// - Up to five groups
// - Negotiated group excess ports wait as standby
// - Active members share speed and full duplex
// - Each group appears as one logical port
// - Group members cannot be mirror ports
// - Report id, name, type, speed, ports
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
module lagsel_top
   import lagsel_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Member port link state
   input wire lagsel_link_s [9:0] link_i,
   // Frames from forwarding engine
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire lagsel_hdr_s in_hdr_i,
   // Egress decision
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [3:0] out_port_o,
   output logic out_drop_o,
   // Logical ports and mirroring limits
   output lagsel_grp_s [4:0] grp_status_o,
   output logic [9:0] mirror_src_o,
   output logic [9:0] mirror_dst_o
);
   //////////////////////////////////////////////////////////////////////
   // Functions
   function automatic logic [3:0] popcnt(input logic [9:0] m);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < `LAGSEL_NPORTS; i++) begin
         c = c + 4'(m[i]);
      end
      popcnt = c;
   endfunction : popcnt

   function automatic logic [9:0] members(input logic [29:0] pg);
      logic [9:0] m;
      m = 10'h000;
      for (int i = 0; i < `LAGSEL_NPORTS; i++) begin
         m[i] = (pg[3*i +: 3] != `LAGSEL_GRP_NONE);
      end
      members = m;
   endfunction : members

   function automatic logic [9:0] of_group(input logic [29:0] pg,
                                           input logic [2:0] g);
      logic [9:0] m;
      m = 10'h000;
      for (int i = 0; i < `LAGSEL_NPORTS; i++) begin
         m[i] = (pg[3*i +: 3] == g);
      end
      of_group = m;
   endfunction : of_group

   function automatic logic [3:0] pick(input logic [9:0] m,
                                       input logic [15:0] h);
      logic [3:0] k, seen, p;
      k = 4'h0;
      seen = 4'h0;
      p = 4'h0;
      if (popcnt(m) != 4'h0) begin
         k = 4'(h % 16'(popcnt(m)));
      end
      for (int i = 0; i < `LAGSEL_NPORTS; i++) begin
         if (m[i]) begin
            if (seen == k) begin
               p = 4'(i);
            end
            seen = seen + 4'h1;
         end
      end
      pick = p;
   endfunction : pick

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      be_merge = r;
   endfunction : be_merge

   //////////////////////////////////////////////////////////////////////
   // Configuration and bus state
   logic [3:0] hash_en_reg, hash_en_next;
   logic [29:0] port_grp_reg, port_grp_next;
   logic [4:0] gtype_reg, gtype_next;
   logic [3:0] limit_reg, limit_next;
   logic [9:0] msrc_reg, msrc_next, mdst_reg, mdst_next;
   logic [2:0] gsel_reg, gsel_next;
   logic [31:0] rdata_reg, rdata_next;
   lagsel_bus_e bus_reg, bus_next;
   lagsel_grp_s [4:0] stat_reg, stat_next;
   logic [31:0] wr_val, rd_val;
   logic [29:0] pg_w;
   lagsel_grp_s cur;

   assign avs_waitrequest_o = (avs_read_i || avs_write_i) &&
                              (bus_reg == BUS_IDLE);
   assign avs_readdata_o = rdata_reg;
   assign cur = (gsel_reg >= 3'h1 && gsel_reg <= `LAGSEL_GRP_MAX) ?
                stat_reg[gsel_reg - 3'h1] : '0;

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (avs_address_i)
         `LAGSEL_OFF_HASH: rd_val = {28'h0, hash_en_reg};
         `LAGSEL_OFF_PGRP: rd_val = {2'h0, port_grp_reg};
         `LAGSEL_OFF_GTYPE: rd_val = {27'h0, gtype_reg};
         `LAGSEL_OFF_LIMIT: rd_val = {28'h0, limit_reg};
         `LAGSEL_OFF_MIRROR: rd_val = {6'h0, mdst_reg, 6'h0, msrc_reg};
         `LAGSEL_OFF_GSEL: rd_val = {29'h0, gsel_reg};
         `LAGSEL_OFF_GSTAT: begin
            rd_val = {cur.speed, cur.agg, cur.cfg, 5'h0, cur.lacp,
                      1'b0, gsel_reg};
         end
         `LAGSEL_OFF_GNAME: begin
            rd_val = `LAGSEL_NAME_BASE + {29'h0, gsel_reg};
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_comb begin
      hash_en_next = hash_en_reg;
      port_grp_next = port_grp_reg;
      gtype_next = gtype_reg;
      limit_next = limit_reg;
      msrc_next = msrc_reg;
      mdst_next = mdst_reg;
      gsel_next = gsel_reg;
      rdata_next = rdata_reg;
      bus_next = bus_reg;
      wr_val = be_merge(rd_val, avs_writedata_i, avs_byteenable_i);
      pg_w = wr_val[29:0];
      for (int i = 0; i < `LAGSEL_NPORTS; i++) begin
         if (pg_w[3*i +: 3] > `LAGSEL_GRP_MAX) begin
            pg_w[3*i +: 3] = `LAGSEL_GRP_NONE;
         end
      end
      unique case (bus_reg)
         BUS_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               bus_next = BUS_ACK;
               rdata_next = avs_read_i ? rd_val : 32'h0000_0000;
            end
         end
         BUS_ACK: begin
            bus_next = BUS_IDLE;
            if (avs_write_i) begin
               unique case (avs_address_i)
                  `LAGSEL_OFF_HASH: hash_en_next = wr_val[3:0];
                  `LAGSEL_OFF_PGRP: port_grp_next = pg_w;
                  `LAGSEL_OFF_GTYPE: gtype_next = wr_val[4:0];
                  `LAGSEL_OFF_LIMIT: begin
                     limit_next = (wr_val[3:0] > `LAGSEL_LIMIT_MAX ||
                                   wr_val[3:0] == 4'h0) ?
                                  `LAGSEL_LIMIT_MAX : wr_val[3:0];
                  end
                  `LAGSEL_OFF_MIRROR: begin
                     msrc_next = wr_val[9:0];
                     mdst_next = wr_val[`LAGSEL_MIR_DST_LSB +: 10];
                  end
                  `LAGSEL_OFF_GSEL: gsel_next = wr_val[2:0];
                  default: ;
               endcase
            end
         end
      endcase
      msrc_next = msrc_next & ~members(port_grp_next);
      mdst_next = mdst_next & ~members(port_grp_next);
   end

   //////////////////////////////////////////////////////////////////////
   // Group membership, speed and standby
   always_comb begin
      logic [9:0] cfg, elig;
      logic [1:0] spd;
      logic found;
      logic [3:0] n;
      cfg = 10'h000;
      elig = 10'h000;
      spd = 2'h0;
      found = 1'b0;
      n = 4'h0;
      stat_next = stat_reg;
      for (int g = 0; g < `LAGSEL_NGROUPS; g++) begin
         cfg = of_group(port_grp_reg, 3'(g + 1));
         found = 1'b0;
         spd = 2'h0;
         for (int i = 0; i < `LAGSEL_NPORTS; i++) begin
            if (!found && cfg[i] && link_i[i].up && link_i[i].fdx) begin
               found = 1'b1;
               spd = link_i[i].speed;
            end
         end
         n = 4'h0;
         for (int i = 0; i < `LAGSEL_NPORTS; i++) begin
            elig[i] = cfg[i] && link_i[i].up && link_i[i].fdx &&
                      (link_i[i].speed == spd);
            if (elig[i] && gtype_reg[g]) begin
               if (n >= limit_reg) begin
                  elig[i] = 1'b0;
               end else begin
                  n = n + 4'h1;
               end
            end
         end
         stat_next[g].lacp = gtype_reg[g];
         stat_next[g].speed = spd;
         stat_next[g].cfg = cfg;
         stat_next[g].agg = elig;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         hash_en_reg <= `LAGSEL_HASH_RST;
         port_grp_reg <= '0;
         gtype_reg <= '0;
         limit_reg <= `LAGSEL_LIMIT_RST;
         msrc_reg <= '0;
         mdst_reg <= '0;
         gsel_reg <= 3'h1;
         rdata_reg <= '0;
         bus_reg <= BUS_IDLE;
         stat_reg <= '0;
      end else begin
         hash_en_reg <= hash_en_next;
         port_grp_reg <= port_grp_next;
         gtype_reg <= gtype_next;
         limit_reg <= limit_next;
         msrc_reg <= msrc_next;
         mdst_reg <= mdst_next;
         gsel_reg <= gsel_next;
         rdata_reg <= rdata_next;
         bus_reg <= bus_next;
         stat_reg <= stat_next;
      end
   end

   assign grp_status_o = stat_reg;
   assign mirror_src_o = msrc_reg;
   assign mirror_dst_o = mdst_reg;

   //////////////////////////////////////////////////////////////////////
   // Frame buffer, hash and egress choice
   lagsel_hdr_s f_hdr;
   logic f_valid, f_ready;
   logic [15:0] hash;
   logic ov_reg, ov_next, drop_reg, drop_next;
   logic [3:0] port_reg, port_next;
   logic [9:0] agg_reg, agg_next;

   lagsel_fifo #(
      .WIDTH($bits(lagsel_hdr_s)),
      .DEPTH(`LAGSEL_FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .in_valid_i(in_valid_i),
      .in_ready_o(in_ready_o),
      .in_data_i(in_hdr_i),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_hdr)
   );

   lagsel_hash u_hash (
      .hdr_i(f_hdr),
      .en_i(hash_en_reg),
      .hash_o(hash)
   );

   assign f_ready = !ov_reg || out_ready_i;

   always_comb begin
      lagsel_grp_s gs;
      gs = '0;
      ov_next = ov_reg && !out_ready_i;
      port_next = port_reg;
      drop_next = drop_reg;
      agg_next = agg_reg;
      if (f_valid && f_ready) begin
         ov_next = 1'b1;
         if (f_hdr.grp == `LAGSEL_GRP_NONE ||
             f_hdr.grp > `LAGSEL_GRP_MAX) begin
            port_next = f_hdr.port;
            drop_next = 1'b0;
            agg_next = 10'h000;
         end else begin
            gs = stat_reg[f_hdr.grp - 3'h1];
            port_next = pick(gs.agg, hash);
            drop_next = (gs.agg == 10'h000);
            agg_next = gs.agg;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ov_reg <= 1'b0;
         port_reg <= 4'h0;
         drop_reg <= 1'b0;
         agg_reg <= 10'h000;
      end else begin
         ov_reg <= ov_next;
         port_reg <= port_next;
         drop_reg <= drop_next;
         agg_reg <= agg_next;
      end
   end

   assign out_valid_o = ov_reg;
   assign out_port_o = port_reg;
   assign out_drop_o = drop_reg;

   //////////////////////////////////////////////////////////////////////
   // Assertions
   logic [3:0] tot;
   assign tot = popcnt(stat_reg[0].agg | stat_reg[1].agg |
                       stat_reg[2].agg | stat_reg[3].agg | stat_reg[4].agg);

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   smac_reset_a: assert property ($past(rst_i) |->
      hash_en_reg[`LAGSEL_HB_SMAC]) else $error("Source MAC off at reset");
   dmac_reset_a: assert property ($past(rst_i) |->
      !hash_en_reg[`LAGSEL_HB_DMAC]) else $error("Dest MAC on at reset");
   ip_reset_a: assert property ($past(rst_i) |->
      hash_en_reg[`LAGSEL_HB_IP]) else $error("IP hash off at reset");
   l4_reset_a: assert property ($past(rst_i) |->
      hash_en_reg[`LAGSEL_HB_L4]) else $error("L4 hash off at reset");
   group_reset_a: assert property ($past(rst_i) |->
      port_grp_reg == '0) else $error("Port in group after reset");
   mirror_excl_a: assert property (
      ((msrc_reg | mdst_reg) & members(port_grp_reg)) == 10'h000)
      else $error("Group member used for mirroring");
   agg_total_a: assert property (tot <= `LAGSEL_LIMIT_MAX)
      else $error("Too many aggregated ports");
   standby_limit_a: assert property (
      gtype_reg[1] |=> popcnt(stat_reg[1].agg) <= $past(limit_reg))
      else $error("Negotiated group above active limit");
   member_pick_a: assert property (
      ov_reg && !drop_reg && agg_reg != 10'h000 |->
      agg_reg[port_reg]) else $error("Chosen port not an active member");
   out_hold_a: assert property (
      ov_reg && !out_ready_i |=> ov_reg && $stable(port_reg))
      else $error("Egress choice changed while stalled");
   bus_ack_a: assert property ((avs_read_i || avs_write_i) &&
      avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("Bus answer late");
   hash_write_c: cover property (bus_reg == BUS_ACK && avs_write_i &&
      avs_address_i == `LAGSEL_OFF_HASH);
   group_pick_c: cover property (ov_reg && !drop_reg &&
      agg_reg != 10'h000 && out_ready_i);
   fifo_full_c: cover property (!in_ready_o);
endmodule : lagsel_top

/* test/lagsel_port_model.sv */
`timescale 1ns/10ps
module lagsel_port_model
   import lagsel_pkg::*;
(
   // Clock
   input wire logic core_clk_i,
   // Stall mode: 0 prompt, 1 random, 2 stopped
   input wire logic [1:0] mode_i,
   // Per port link up, full duplex, low speed
   input wire logic [9:0] up_i,
   input wire logic [9:0] fdx_i,
   input wire logic [9:0] slow_i,
   // Link state and egress acceptance
   output lagsel_link_s [9:0] link_o,
   output logic ready_o
);
   // A port that is down shows no settled speed
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         link_o[i].speed = !up_i[i] ? 2'h3 : slow_i[i] ? 2'h1 : 2'h2;
         link_o[i].fdx = fdx_i[i];
         link_o[i].up = up_i[i];
      end
   end
   initial ready_o = 1'b0;
   // Random stalls model a congested egress port
   always @(posedge core_clk_i) begin
      ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && $urandom_range(1) == 1);
   end
endmodule : lagsel_port_model

/* test/lagsel_top_tb.sv */
`timescale 1ns/10ps
`include "lagsel_defines.svh"
module lagsel_top_tb
   import lagsel_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] adr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat, w, rd_s;
   logic wreq, in_ready, out_valid, ready, out_drop, ack_s, ir_s;
   lagsel_link_s [9:0] link;
   logic in_valid = 1'b0;
   lagsel_hdr_s in_hdr = '0;
   logic [3:0] out_port;
   lagsel_grp_s [4:0] gstat;
   lagsel_grp_s s_e;
   logic [9:0] msrc, mdst;
   logic [1:0] rmode = 2'h0;
   logic [9:0] up = '1;
   logic [9:0] fdx = '1;
   logic [9:0] slow = '0;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;
   int lim = 8;
   int gmap[10] = '{default: 0};
   logic [5:0] lacp = '0;
   logic [3:0] hen = 4'hd;
   logic [3:0] modes[6] = '{4'hd, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
   lagsel_hdr_s expq[$];
   logic [3:0] flow[lagsel_hdr_s];

   always #25 core_clk = ~core_clk;

   lagsel_top i_dut (.core_clk_i(core_clk), .rst_i(rst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .link_i(link),
      .in_valid_i(in_valid), .in_ready_o(in_ready), .in_hdr_i(in_hdr),
      .out_valid_o(out_valid), .out_ready_i(ready), .out_port_o(out_port),
      .out_drop_o(out_drop), .grp_status_o(gstat), .mirror_src_o(msrc),
      .mirror_dst_o(mdst));

   lagsel_port_model i_ports (.core_clk_i(core_clk), .mode_i(rmode),
      .up_i(up), .fdx_i(fdx), .slow_i(slow), .link_o(link),
      .ready_o(ready));

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      adr <= a;
      wdat <= d;
      rd <= !we;
      wr <= we;
      do begin
         @(posedge core_clk);
      end while (!ack_s);
      q = rd_s;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic wrt(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wrt

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, '0, q);
      chk(q, e);
   endtask : rdc

   ////////////////////////////////////////////////////////////////////////
   // Expected group state from configuration and link state
   function automatic lagsel_grp_s gexp(int g);
      lagsel_grp_s s;
      int c;
      s = '0;
      c = 0;
      s.lacp = lacp[g];
      for (int i = 9; i >= 0; i--) begin
         s.cfg[i] = gmap[i] == g;
         if (s.cfg[i] && up[i] && fdx[i]) s.speed = slow[i] ? 2'h1 : 2'h2;
      end
      for (int i = 0; i < 10; i++) begin
         if (s.cfg[i] && up[i] && fdx[i] && (!s.lacp || c < lim) &&
             s.speed == (slow[i] ? 2'h1 : 2'h2)) begin
            s.agg[i] = 1'b1;
            c++;
         end
      end
      return s;
   endfunction : gexp

   // Flow key: only the enabled fields pick the member
   function automatic lagsel_hdr_s fkey(lagsel_hdr_s h);
      h.port = '0;
      if (!hen[0]) h.smac = '0;
      if (!hen[1]) h.dmac = '0;
      if (!hen[2] || !h.ipv4) {h.sip, h.dip} = '0;
      if (!hen[3] || !h.ipv4) {h.sport, h.dport} = '0;
      return h;
   endfunction : fkey

   function automatic int low(logic [9:0] m);
      low = 0;
      for (int i = 9; i >= 0; i--) if (m[i]) low = i;
   endfunction : low

   function automatic lagsel_hdr_s rnd_hdr();
      lagsel_hdr_s h;
      h = '0;
      h.smac = 48'($urandom_range(3));
      h.dmac = 48'($urandom_range(3));
      h.ipv4 = 1'($urandom_range(1));
      h.sip = 32'($urandom_range(3));
      h.dip = 32'($urandom_range(3));
      h.sport = 16'($urandom_range(3));
      h.dport = 16'($urandom_range(3));
      h.grp = 3'($urandom_range(5));
      h.port = 4'($urandom_range(9));
      return h;
   endfunction : rnd_hdr

   task automatic check();
      lagsel_hdr_s h, k;
      lagsel_grp_s s;
      if (expq.size() == 0) begin
         chk(out_valid, 1'b0);
         return;
      end
      h = expq.pop_front();
      s = gexp(h.grp);
      k = fkey(h);
      if (h.grp == 3'h0) begin
         chk({out_drop, out_port}, {1'b0, h.port});
      end else begin
         chk(out_drop, s.agg == '0);
         if (s.agg != '0) begin
            chk(s.agg[out_port], 1'b1);
            if (hen == 4'h0) chk(out_port, low(s.agg));
            if (flow.exists(k)) chk(out_port, flow[k]);
            else flow[k] = out_port;
         end
      end
   endtask : check

   always @(negedge core_clk) begin
      ack_s = (rd | wr) && wreq === 1'b0;
      ir_s = in_ready === 1'b1;
      rd_s = rdat;
      if (out_valid === 1'b1 && ready === 1'b1) check();
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic drain();
      for (int k = 0; k < 2000 && expq.size() > 0; k++) @(posedge core_clk);
      chk(expq.size(), 0);
   endtask : drain

   task automatic send(input int cnt);
      flow.delete();
      @(posedge core_clk);
      in_hdr <= rnd_hdr();
      in_valid <= 1'b1;
      while (cnt > 0) begin
         @(posedge core_clk);
         if (ir_s) begin
            expq.push_back(in_hdr);
            cnt--;
            in_hdr <= rnd_hdr();
         end
      end
      in_valid <= 1'b0;
      drain();
   endtask : send

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hd26436fd));
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      rdc(`LAGSEL_OFF_HASH, 32'hd);
      rdc(`LAGSEL_OFF_PGRP, 32'h0);
      rdc(`LAGSEL_OFF_LIMIT, 32'h8);
      rdc(8'h40, 32'h0);
      for (int g = 0; g < 5; g++) chk(gstat[g], '0);
      // Mixed groups: low speed, half duplex, down, bad code, standby
      gmap = '{1, 1, 1, 1, 1, 1, 2, 2, 6, 5};
      slow[3] <= 1'b1;
      fdx[4] <= 1'b0;
      up[5] <= 1'b0;
      w = '0;
      for (int i = 0; i < 10; i++) w[3*i +: 3] = 3'(gmap[i]);
      wrt(`LAGSEL_OFF_PGRP, w);
      gmap[8] = 0;
      w[26:24] = 3'h0;
      rdc(`LAGSEL_OFF_PGRP, w);
      lacp[2] = 1'b1;
      lim = 1;
      wrt(`LAGSEL_OFF_GTYPE, 32'h2);
      wrt(`LAGSEL_OFF_LIMIT, 32'h1);
      repeat (3) @(posedge core_clk);
      for (int g = 1; g < 6; g++) chk(gstat[g-1], gexp(g));
      wrt(`LAGSEL_OFF_GSEL, 32'h2);
      s_e = gexp(2);
      rdc(`LAGSEL_OFF_GSTAT, {s_e.speed, s_e.agg, s_e.cfg, 5'h0, s_e.lacp,
          1'b0, 3'h2});
      rdc(`LAGSEL_OFF_GNAME, `LAGSEL_NAME_BASE + 32'h2);
      wrt(`LAGSEL_OFF_MIRROR, 32'h03ff03ff);
      rdc(`LAGSEL_OFF_MIRROR, 32'h01000100);
      chk({mdst, msrc}, 20'h40100);
      // Every hash field alone, the reset set (all but DMAC), none; prompt and stalling egress
      for (int j = 0; j < 6; j++) begin
         hen = modes[j];
         wrt(`LAGSEL_OFF_HASH, {28'h0, hen});
         rdc(`LAGSEL_OFF_HASH, {28'h0, hen});
         rmode <= 2'(j % 2);
         send(60);
      end
      // Active member fails, standby takes over
      up[6] <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(gstat[1], gexp(2));
      send(40);
      wrt(`LAGSEL_OFF_LIMIT, 32'h0);
      rdc(`LAGSEL_OFF_LIMIT, 32'ha);
      lim = 10;
      // Fill the frame buffer against a stopped egress
      rmode <= 2'h2;
      repeat (2) @(posedge core_clk);
      n = 0;
      in_hdr <= rnd_hdr();
      in_valid <= 1'b1;
      repeat (24) begin
         @(posedge core_clk);
         if (ir_s) begin
            expq.push_back(in_hdr);
            n++;
            in_hdr <= rnd_hdr();
         end
      end
      in_valid <= 1'b0;
      chk(n >= 16 && n <= 17 && !ir_s, 1'b1);
      rmode <= 2'h1;
      drain();
      test_done();
   end
endmodule : lagsel_top_tb
